// ---- hw/vcf_consts.svh ----
/*
 * Offsets, field positions, reset values and write masks of the channel
 * fault and configuration page. Assumes it is included by bare name.
 */
`ifndef VCF_CONSTS_SVH
`define VCF_CONSTS_SVH

// ****************************************
// Register indices on the channel page
// ****************************************
`define VCF_IDX_STAT_A   5'h00
`define VCF_IDX_STAT_B   5'h01
`define VCF_IDX_CFG      5'h02
`define VCF_IDX_TEST     5'h03
`define VCF_IDX_DITH_A   5'h04
`define VCF_IDX_DITH_B   5'h05

// ****************************************
// Reset values and writable bits
// ****************************************
`define VCF_RST_ZERO     16'h0000
`define VCF_RST_DITH_A   16'h0050
`define VCF_RST_DITH_B   16'h028a
`define VCF_WM_CFG       16'h67ef
`define VCF_WM_TEST      16'h0003
`define VCF_WM_DITH_A    16'he0ff
`define VCF_WM_DITH_B    16'h1f3f

// ****************************************
// Fault status A fields
// ****************************************
`define VCF_RC_MASK_A    16'h99ff
`define VCF_A_TWARN      15
`define VCF_A_CAL_CRC    14
`define VCF_A_TRIM_CRC   13
`define VCF_A_PWM_FLT    12
`define VCF_A_PWM_MIS    11
`define VCF_A_BIST       10:9
`define VCF_A_DIAG       8:7
`define VCF_A_OPEN       6
`define VCF_A_SHORT      5
`define VCF_A_ADC        4
`define VCF_A_CLAMP      3
`define VCF_A_HSOC       2
`define VCF_A_LSOC       1
`define VCF_A_TSD        0

// ****************************************
// Fault status B fields
// ****************************************
`define VCF_B_GND_RUN    5
`define VCF_B_OOR        4
`define VCF_B_GND_LOSS   3
`define VCF_B_RAM_CRC    2
`define VCF_B_HSLS       1
`define VCF_B_CFG_MON    0
`define VCF_OOR_PWM_CYC  8

// ****************************************
// Config, launch and dither fields
// ****************************************
`define VCF_C_OFS_DIS    14
`define VCF_C_CAL_DIS    13
`define VCF_C_BIST_EN    10
`define VCF_C_BLANK      9
`define VCF_C_RANGE      8
`define VCF_C_OVC        6
`define VCF_C_OFF_DIAG   5
`define VCF_C_HS_LOAD    3
`define VCF_C_SW_FB      2
`define VCF_C_SLEW       1:0
`define VCF_T_DIAG       1
`define VCF_T_GND        0
`define VCF_D_EN         15
`define VCF_D_SYNC_EN    14
`define VCF_D_SYNC_PER   13
`define VCF_D_ISTEP      7:0
`define VCF_D_NSTEP      12:8

`endif

// ---- hw/vcf_pkg.sv ----
/*
 * Types shared by the channel fault and configuration page.
 * Assumes nothing.
 */
package vcf_pkg;

    // ****************************************
    // Field encodings
    // ****************************************
    typedef enum logic [1:0] {
        VCF_BIST_IDLE = 2'h0,
        VCF_BIST_RUN  = 2'h1,
        VCF_BIST_PASS = 2'h2,
        VCF_BIST_FAIL = 2'h3
    } vcf_bist_t;

    typedef enum logic [1:0] {
        VCF_DIAG_PASS    = 2'h0,
        VCF_LOW_VOLTAGE_COMPARATOR_FAIL = 2'h1,
        VCF_DIAG_OL_FAIL = 2'h2,
        VCF_DIAG_FAIL    = 2'h3
    } vcf_diag_t;

    typedef enum logic [1:0] {
        VCF_SLEW_0V4 = 2'h0,
        VCF_SLEW_1V0 = 2'h1,
        VCF_SLEW_4V0 = 2'h2,
        VCF_SLEW_8V0 = 2'h3
    } vcf_slew_t;

    typedef logic [15:0] vcf_word_t;

endpackage

// ---- hw/vcf_flag_if.sv ----
/*
 * Carrier between the page and a sticky flag bank.
 * Assumes both ends share one clock and reset.
 */
interface vcf_flag_if #(
    parameter int W = 16
);
    logic [W-1:0] ev;       // Set requests
    logic [W-1:0] clr;      // Clear requests from a read
    logic [W-1:0] flags;    // Held flags

    modport bank (input ev, input clr, output flags);
    modport user (output ev, output clr, input flags);
endinterface

// ---- hw/vcf_flag_bank.sv ----
/*
 * Sticky flags cleared by a read; set wins.
 * Assumes a synchronised reset.
 */
module vcf_flag_bank #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic    clk,
    input  wire logic    rst_sync_n,
    // Flag carrier
    vcf_flag_if.bank     fl
);
    logic [W-1:0] flags_q;  // Held flags

    // ****************************************
    // Flag storage
    // ****************************************
    // Set wins over clear, so a lasting fault re-arms at once
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~fl.clr) | fl.ev;
        end
    end

    assign fl.flags = flags_q;
endmodule

// ---- hw/vcf_regs.sv ----
/*
 * Fault status, configuration, test launch and dither registers
 * of one valve channel.
 * Assumes one-cycle read and write strobes with a page index,
 * and engines that report faults.
 */
`include "vcf_consts.svh"

// How it works
// - Thermal warning and shutdown flags clear on read
// - Calibration and trim checksum bits are live
// - On-state pulse-width faults latch, clear on read
// - Logic self-test status shows idle/run/pass/fail
// - Off-state diagnostic result latches, clears on read
// - Off-state open load and short latch
// - Converter disagreement latches, clears on read
// - On-state clamp and overcurrent flags latch
// - Ground-loss test running bit shows progress
// - Out of regulation after eight cycles latches
// - Ground loss, RAM, compare, monitor faults latch
// - Offset and calibration disable bits
// - Logic self-test held in reset when zero
// - Blanking time select, long or short
// - Current range select, 1.5A or 2.0A
// - Overcurrent threshold select, 4A or 5A
// - Off-state diagnostics enable bit
// - Load side and feedback mode selects
// - Output slew rate code
// - Self-test launch bits hold until done
// - Dither enable, sync enable, sync type
// - Step amplitude and quarter-period step count
module vcf_regs
    import vcf_pkg::*;
#(
    parameter int OOR_CYCLES = `VCF_OOR_PWM_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Register access
    input  wire logic [4:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_rd_en,
    output logic [15:0]      reg_rdata,
    output logic             reg_rd_valid,
    // Driver state
    input  wire logic        out_on,
    // Fault reports for status A
    input  wire logic        thermal_warn,
    input  wire logic        thermal_shutdown_flag,
    input  wire logic        current_sense_amp_crc_err,
    input  wire logic        converter_trim_crc_err,
    input  wire logic        pwm_chk_fault,
    input  wire logic        pwm_chk_mismatch,
    input  wire vcf_bist_t   logic_bist_status,
    input  wire logic        diag_result_valid,
    input  wire vcf_diag_t   diag_result,
    input  wire logic        open_load_det,
    input  wire logic        short_det,
    input  wire logic        adc_mismatch,
    input  wire logic        ls_clamp_act,
    input  wire logic        hs_overcurrent,
    input  wire logic        ls_overcurrent,
    // Fault reports for status B
    input  wire logic        pwm_cycle_end,
    input  wire logic        out_of_reg,
    input  wire logic        solenoid_ground_loss,
    input  wire logic        ram_crc_err,
    input  wire logic        hs_ls_cmp_fault,
    input  wire logic        cfg_monitor_fault,
    // Self-test engines
    input  wire logic        diag_test_done,
    input  wire logic        gnd_test_done,
    output logic             diag_test_start,
    output logic             gnd_test_start,
    // Channel configuration
    output logic             offset_comp_disable,
    output logic             sense_cal_disable,
    output logic             logic_bist_enable,
    output logic             blank_time_select,
    output logic             high_range_select,
    output logic             ovc_threshold_high,
    output logic             off_diag_enable,
    output logic             high_side_load,
    output logic             sw_feedback,
    output vcf_slew_t        slew_rate,
    // Dither generator setup
    output logic             dither_enable,
    output logic             dither_sync_enable,
    output logic             dither_sync_period,
    output logic [7:0]       dither_istep,
    output logic [4:0]       dither_nstep
);

    // ****************************************
    // Helpers
    // ****************************************
    // Access targets the given index
    function automatic logic hit(input logic [4:0] a, input logic [4:0] idx);
        hit = (a == idx);
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    logic        rst_m_q;       // Reset synchroniser, first stage
    logic        rst_s_q;       // Released reset for the design
    vcf_word_t   cfg_q;         // Main configuration word
    vcf_word_t   test_q;        // Self-test launch word
    vcf_word_t   dith_a_q;      // Dither setup A
    vcf_word_t   dith_b_q;      // Dither setup B
    vcf_word_t   stat_a;        // Status A as read
    vcf_word_t   stat_b;        // Status B as read
    vcf_word_t   rd_mux;        // Selected read value
    vcf_word_t   rdata_q;       // Registered read data
    logic        rd_valid_q;    // Read answer strobe
    logic [3:0]  oor_cnt_q;     // Out-of-regulation run
    logic        oor_hit;       // Limit reached this cycle end
    logic        diag_st_q;     // Diagnostic test start pulse
    logic        gnd_st_q;      // Ground-loss test start pulse
    logic        wr_test;       // Write to the launch word

    vcf_flag_if #(.W(16)) fa ();    // Status A sticky flags
    vcf_flag_if #(.W(16)) fb ();    // Status B sticky flags

    // ****************************************
    // Reset release
    // ****************************************
    // Two stages keep the release clean
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // ****************************************
    // Sticky flag banks
    // ****************************************
    vcf_flag_bank #(.W(16)) u_bank_a (
        .clk        (ref_clk),
        .rst_sync_n (rst_s_q),
        .fl         (fa.bank)
    );

    vcf_flag_bank #(.W(16)) u_bank_b (
        .clk        (ref_clk),
        .rst_sync_n (rst_s_q),
        .fl         (fb.bank)
    );

    // Set requests for status A; PWM, open, short, clamp and overcurrent gated by driver state
    always_comb begin
        fa.ev = '0;
        fa.ev[`VCF_A_TWARN]   = thermal_warn;
        fa.ev[`VCF_A_TSD]     = thermal_shutdown_flag;
        fa.ev[`VCF_A_PWM_FLT] = pwm_chk_fault & out_on;
        fa.ev[`VCF_A_PWM_MIS] = pwm_chk_mismatch & out_on;
        // Off-state diagnostic result code
        if (diag_result_valid) begin
            fa.ev[`VCF_A_DIAG] = diag_result;
        end
        // Off-state checks only while diagnostics are enabled
        fa.ev[`VCF_A_OPEN]  = open_load_det & ~out_on & off_diag_enable;
        fa.ev[`VCF_A_SHORT] = short_det & ~out_on & off_diag_enable;
        fa.ev[`VCF_A_ADC]   = adc_mismatch;
        fa.ev[`VCF_A_CLAMP] = ls_clamp_act & out_on;
        fa.ev[`VCF_A_HSOC]  = hs_overcurrent & out_on;
        fa.ev[`VCF_A_LSOC]  = ls_overcurrent & out_on;
    end

    // Set requests for status B
    always_comb begin
        fb.ev = '0;
        fb.ev[`VCF_B_OOR]      = oor_hit;
        fb.ev[`VCF_B_GND_LOSS] = solenoid_ground_loss;
        fb.ev[`VCF_B_RAM_CRC]  = ram_crc_err;
        fb.ev[`VCF_B_HSLS]     = hs_ls_cmp_fault;
        fb.ev[`VCF_B_CFG_MON]  = cfg_monitor_fault;
    end

    // A read clears the clear-on-read bits it returned
    always_comb begin
        fa.clr = '0;
        fb.clr = '0;
        if (reg_rd_en && hit(reg_addr, `VCF_IDX_STAT_A)) begin
            fa.clr = fa.flags & `VCF_RC_MASK_A;
        end
        if (reg_rd_en && hit(reg_addr, `VCF_IDX_STAT_B)) begin
            fb.clr = fb.flags;
        end
    end

    // ****************************************
    // Out-of-regulation counter
    // ****************************************
    // Counts out-of-regulation PWM cycles in a row
    assign oor_hit = pwm_cycle_end & out_of_reg
                   & (oor_cnt_q == 4'(OOR_CYCLES - 1));

    always_ff @(posedge ref_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            oor_cnt_q <= '0;
        end else if (pwm_cycle_end) begin
            // Back in regulation restarts the run
            if (!out_of_reg) begin
                oor_cnt_q <= '0;
            end else if (oor_cnt_q != 4'(OOR_CYCLES)) begin
                oor_cnt_q <= oor_cnt_q + 4'h1;
            end
        end
    end

    // ****************************************
    // Status words as read
    // ****************************************
    always_comb begin
        stat_a = fa.flags & `VCF_RC_MASK_A;
        stat_a[`VCF_A_CAL_CRC]  = current_sense_amp_crc_err;
        stat_a[`VCF_A_TRIM_CRC] = converter_trim_crc_err;
        // Self-test in reset reads idle
        stat_a[`VCF_A_BIST] = logic_bist_enable ? logic_bist_status
                                                : VCF_BIST_IDLE;
        stat_b = fb.flags;
        stat_b[`VCF_B_GND_RUN] = test_q[`VCF_T_GND];
    end

    // ****************************************
    // Configuration word
    // ****************************************
    // Only writable bits take write data
    always_ff @(posedge ref_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            cfg_q <= `VCF_RST_ZERO;
        end else if (reg_wr_en && hit(reg_addr, `VCF_IDX_CFG)) begin
            cfg_q <= reg_wdata & `VCF_WM_CFG;
        end
    end

    assign offset_comp_disable = cfg_q[`VCF_C_OFS_DIS];
    assign sense_cal_disable   = cfg_q[`VCF_C_CAL_DIS];
    assign logic_bist_enable   = cfg_q[`VCF_C_BIST_EN];
    assign blank_time_select   = cfg_q[`VCF_C_BLANK];
    assign high_range_select   = cfg_q[`VCF_C_RANGE];
    assign ovc_threshold_high  = cfg_q[`VCF_C_OVC];
    assign off_diag_enable     = cfg_q[`VCF_C_OFF_DIAG];
    assign high_side_load      = cfg_q[`VCF_C_HS_LOAD];
    assign sw_feedback         = cfg_q[`VCF_C_SW_FB];
    assign slew_rate           = vcf_slew_t'(cfg_q[`VCF_C_SLEW]);

    // ****************************************
    // Self-test launch word
    // ****************************************
    assign wr_test = reg_wr_en & hit(reg_addr, `VCF_IDX_TEST);

    // A one sets a launch bit; only done clears it
    always_ff @(posedge ref_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            test_q <= `VCF_RST_ZERO;
        end else begin
            // Short, open load and PWM check test
            if (wr_test && reg_wdata[`VCF_T_DIAG]) begin
                test_q[`VCF_T_DIAG] <= 1'b1;
            end else if (diag_test_done) begin
                test_q[`VCF_T_DIAG] <= 1'b0;
            end
            // Ground-loss test
            if (wr_test && reg_wdata[`VCF_T_GND]) begin
                test_q[`VCF_T_GND] <= 1'b1;
            end else if (gnd_test_done) begin
                test_q[`VCF_T_GND] <= 1'b0;
            end
        end
    end

    // Start pulses only when an idle test launches
    always_ff @(posedge ref_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            diag_st_q <= 1'b0;
            gnd_st_q  <= 1'b0;
        end else begin
            diag_st_q <= wr_test & reg_wdata[`VCF_T_DIAG]
                       & ~test_q[`VCF_T_DIAG];
            gnd_st_q  <= wr_test & reg_wdata[`VCF_T_GND]
                       & ~test_q[`VCF_T_GND];
        end
    end

    assign diag_test_start = diag_st_q;
    assign gnd_test_start  = gnd_st_q;

    // ****************************************
    // Dither setup words
    // ****************************************
    // Bits outside the write masks keep their reset value
    always_ff @(posedge ref_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            dith_a_q <= `VCF_RST_DITH_A;
            dith_b_q <= `VCF_RST_DITH_B;
        end else begin
            if (reg_wr_en && hit(reg_addr, `VCF_IDX_DITH_A)) begin
                dith_a_q <= (dith_a_q & ~`VCF_WM_DITH_A)
                          | (reg_wdata & `VCF_WM_DITH_A);
            end
            if (reg_wr_en && hit(reg_addr, `VCF_IDX_DITH_B)) begin
                dith_b_q <= (dith_b_q & ~`VCF_WM_DITH_B)
                          | (reg_wdata & `VCF_WM_DITH_B);
            end
        end
    end

    assign dither_enable      = dith_a_q[`VCF_D_EN];
    assign dither_sync_enable = dith_a_q[`VCF_D_SYNC_EN];
    assign dither_sync_period = dith_a_q[`VCF_D_SYNC_PER];
    assign dither_istep       = dith_a_q[`VCF_D_ISTEP];
    assign dither_nstep       = dith_b_q[`VCF_D_NSTEP];

    // ****************************************
    // Read path
    // ****************************************
    // Unmapped indices read as zero
    always_comb begin
        case (reg_addr)
            `VCF_IDX_STAT_A: rd_mux = stat_a;
            `VCF_IDX_STAT_B: rd_mux = stat_b;
            `VCF_IDX_CFG:    rd_mux = cfg_q;
            `VCF_IDX_TEST:   rd_mux = test_q;
            `VCF_IDX_DITH_A: rd_mux = dith_a_q;
            `VCF_IDX_DITH_B: rd_mux = dith_b_q;
            default:         rd_mux = `VCF_RST_ZERO;
        endcase
    end

    // Read data captured at the strobe's edge
    always_ff @(posedge ref_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            rdata_q    <= `VCF_RST_ZERO;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= reg_rd_en;
            if (reg_rd_en) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign reg_rdata    = rdata_q;
    assign reg_rd_valid = rd_valid_q;

endmodule

// ---- testbench/vcf_checker.sv ----
/*
 * Port assertions of the channel page.
 * Assumes a bind onto vcf_regs with every pin matched by name.
 */
module vcf_checker
    import vcf_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Register access
    input wire logic [4:0]  reg_addr,
    input wire logic        reg_wr_en,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_rd_en,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rd_valid,
    // Fault and test signals
    input wire logic        thermal_shutdown_flag,
    input wire logic        current_sense_amp_crc_err,
    input wire logic        converter_trim_crc_err,
    input wire logic        logic_bist_enable,
    input wire logic        gnd_test_start,
    input wire logic        diag_test_start,
    // Setup outputs
    input wire logic        offset_comp_disable,
    input wire vcf_slew_t   slew_rate,
    input wire logic        dither_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_a, wr_t;   // Status A read, launch word write
    assign rd_a = reg_rd_en && reg_addr == 5'h00;
    assign wr_t = reg_wr_en && reg_addr == 5'h03;
    // ****************************************
    // Port relations
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rd_ans; reg_rd_en |=> reg_rd_valid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_tsd; rd_a && $past(thermal_shutdown_flag) |=> reg_rdata[0]; endproperty
    a_tsd: assert property (p_tsd) else $error("shutdown flag lost");
    property p_crc;
        rd_a |=>
            reg_rdata[14:13] == $past({current_sense_amp_crc_err, converter_trim_crc_err});
    endproperty
    a_crc: assert property (p_crc) else $error("checksum bits not live");
    property p_bist; rd_a && !logic_bist_enable |=> reg_rdata[10:9] == 2'b00; endproperty
    a_bist: assert property (p_bist) else $error("self test not idle");
    property p_gnd; gnd_test_start |-> $past(wr_t && reg_wdata[0]) ##1 !gnd_test_start;
    endproperty
    a_gnd: assert property (p_gnd) else $error("bad ground test start");
    property p_diag; diag_test_start |-> $past(wr_t && reg_wdata[1]) ##1 !diag_test_start;
    endproperty
    a_diag: assert property (p_diag) else $error("bad diag test start");
    property p_cfg;
        reg_wr_en && reg_addr == 5'h02 |=> offset_comp_disable == $past(reg_wdata[14])
            && slew_rate == $past(reg_wdata[1:0]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config outputs stale");
    property p_dith; reg_wr_en && reg_addr == 5'h04 |=> dither_enable == $past(reg_wdata[15]); endproperty
    a_dith: assert property (p_dith) else $error("dither enable stale");
endmodule

bind vcf_regs vcf_checker vcf_checker_i (.*);

// ---- testbench/vcf_host.sv ----
/*
 * Host model issuing page reads and writes.
 * Assumes a read answer within four cycles.
 */
module vcf_host (
    // Clock and answer
    input wire logic         ref_clk,
    input wire logic [15:0]  reg_rdata,
    input wire logic         reg_rd_valid,
    // Request
    output logic [4:0]       reg_addr,
    output logic             reg_wr_en,
    output logic [15:0]      reg_wdata,
    output logic             reg_rd_en
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reg_addr, reg_wr_en, reg_wdata, reg_rd_en} = '0;
    // One-cycle write strobe, then scrambled bus
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk) #1;
        {reg_addr, reg_wdata, reg_wr_en} = {a, d, 1'b1};
        @(posedge ref_clk) #1;
        {reg_addr, reg_wdata, reg_wr_en} = {~a, ~d, 1'b0};
    endtask
    // Read strobe, bounded wait for the answer
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        int n;
        @(posedge ref_clk) #1;
        {reg_addr, reg_rd_en} = {a, 1'b1};
        @(posedge ref_clk) #1;
        {reg_addr, reg_rd_en} = {~a, 1'b0};
        n = 0;
        while (reg_rd_valid !== 1'b1 && n < 4) begin
            @(posedge ref_clk) #1;
            n++;
        end
        d = (reg_rd_valid === 1'b1) ? reg_rdata : 16'hxxxx;
    endtask
    // Launch a test once the launch word reads zero
    task automatic launch(input logic [15:0] v, output logic ok);
        logic [15:0] d;
        int n;
        n = 0;
        d = 16'hffff;
        while (d !== 16'h0000 && n < 8) begin
            rd(5'h03, d);
            n++;
        end
        ok = (d === 16'h0000);
        if (ok) wr(5'h03, v);
    endtask
endmodule

// ---- testbench/tb_valve_channel_fault_cfg_regs.sv ----
/*
 * Self-checking bench of the channel page.
 * Assumes vcf_host drives the register strobes.
 */
module tb_valve_channel_fault_cfg_regs;
    import vcf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, out_on, diag_result_valid, pwm_cycle_end, out_of_reg, ok;
    logic current_sense_amp_crc_err, converter_trim_crc_err, diag_test_done, gnd_test_done;
    logic thermal_warn, thermal_shutdown_flag, pwm_chk_fault, pwm_chk_mismatch, open_load_det;
    logic short_det, adc_mismatch, ls_clamp_act, hs_overcurrent, ls_overcurrent;
    logic solenoid_ground_loss, ram_crc_err, hs_ls_cmp_fault, cfg_monitor_fault;
    logic diag_test_start, gnd_test_start, reg_wr_en, reg_rd_en, reg_rd_valid;
    logic offset_comp_disable, sense_cal_disable, logic_bist_enable, blank_time_select;
    logic high_range_select, ovc_threshold_high, off_diag_enable, high_side_load, sw_feedback;
    logic dither_enable, dither_sync_enable, dither_sync_period;
    logic [4:0]  reg_addr, dither_nstep;
    logic [7:0]  dither_istep;
    logic [13:0] ev;        // Fault events
    logic [15:0] reg_wdata, reg_rdata;
    vcf_bist_t   logic_bist_status;
    vcf_diag_t   diag_result;
    vcf_slew_t   slew_rate;
    int          failures, total_checks;
    assign {thermal_warn, thermal_shutdown_flag, pwm_chk_fault, pwm_chk_mismatch, open_load_det,
            short_det, adc_mismatch, ls_clamp_act, hs_overcurrent, ls_overcurrent,
            solenoid_ground_loss, ram_crc_err, hs_ls_cmp_fault, cfg_monitor_fault} = ev;
    vcf_regs #(.OOR_CYCLES(8)) vcf_regs_i (.*);
    vcf_host vcf_host_i (.*);
    // ****************************************
    // Helpers
    // ****************************************
    task automatic close_out();
        if (failures == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input string nm, input logic [4:0] a, input logic [15:0] e);
        logic [15:0] d;
        vcf_host_i.rd(a, d);
        chk(nm, e, d);
        if (d === 16'hxxxx) close_out();
    endtask
    task automatic pulse(input logic [13:0] v, input logic dv);
        @(posedge ref_clk) #1;
        {ev, diag_result_valid, pwm_cycle_end} = {v, dv, v == 0};
        @(posedge ref_clk) #1;
        {ev, diag_result_valid, pwm_cycle_end} = '0;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [15:0] rv [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0050, 16'h028a, 16'h0};
        for (int i = 0; i < 7; i++) rdc("reset", 5'(i), rv[i]);
        chk("dith steps", 16'h0250, {3'h0, dither_nstep, dither_istep});
    endtask
    task automatic t_cfg();
        logic [15:0] v [4] = '{16'h2a54, 16'h5569, 16'h00aa, 16'hffff};
        foreach (v[i]) begin
            vcf_host_i.wr(5'h02, v[i]);
            rdc("cfg", 5'h02, v[i] & 16'h67ef);
            chk("cfg out", {v[i][14:13], v[i][10:8], v[i][6:5], v[i][3:0]},
                {offset_comp_disable, sense_cal_disable, logic_bist_enable, blank_time_select,
                 high_range_select, ovc_threshold_high, off_diag_enable, high_side_load,
                 sw_feedback, slew_rate});
        end
        vcf_host_i.wr(5'h04, 16'hffff);
        rdc("dith a", 5'h04, 16'he0ff);
        chk("dith out", 16'hffff, {dither_enable, dither_sync_enable, dither_sync_period,
            5'h1f, dither_istep});
        vcf_host_i.wr(5'h05, 16'h0000);
        rdc("dith b", 5'h05, 16'h0080);
        vcf_host_i.wr(5'h07, 16'hffff);
        rdc("unmapped", 5'h07, 16'h0000);
    endtask
    task automatic t_faults();
        {out_on, current_sense_amp_crc_err, converter_trim_crc_err} = 3'b111;
        logic_bist_status = VCF_BIST_PASS;
        pulse(14'h3fff, 1'b0);
        rdc("stat a on", 5'h00, 16'hfc1f);
        rdc("stat b", 5'h01, 16'h000f);
        rdc("stat a cleared", 5'h00, 16'h6400);
        {out_on, current_sense_amp_crc_err, converter_trim_crc_err} = 3'b000;
        diag_result = VCF_LOW_VOLTAGE_COMPARATOR_FAIL;
        pulse(14'h3fff, 1'b1);
        rdc("stat a off", 5'h00, 16'h84f1);
        rdc("stat b off", 5'h01, 16'h000f);
        ev = 14'h1000;
        rdc("lasting", 5'h00, 16'h0401);
        rdc("lasting", 5'h00, 16'h0401);
        ev = 14'h0000;
        rdc("lasting end", 5'h00, 16'h0401);
        rdc("lasting end", 5'h00, 16'h0400);
        vcf_host_i.wr(5'h02, 16'h0000);
        logic_bist_status = VCF_BIST_FAIL;
        pulse(14'h0300, 1'b0);
        rdc("off diag gated", 5'h00, 16'h0000);
    endtask
    task automatic t_oor();
        out_of_reg = 1'b1;
        for (int i = 0; i < 7; i++) pulse(14'h0000, 1'b0);
        rdc("oor 7", 5'h01, 16'h0000);
        pulse(14'h0000, 1'b0);
        rdc("oor 8", 5'h01, 16'h0010);
        rdc("oor read", 5'h01, 16'h0000);
    endtask
    task automatic t_test();
        vcf_host_i.launch(16'h0001, ok);
        chk("launch", 16'h0001, {15'h0, ok});
        rdc("gnd run", 5'h01, 16'h0020);
        vcf_host_i.wr(5'h03, 16'h0000);
        rdc("launch held", 5'h03, 16'h0001);
        {gnd_test_done, diag_test_done} = 2'b10;
        @(posedge ref_clk) #1 {gnd_test_done, diag_test_done} = 2'b00;
        rdc("gnd done", 5'h01, 16'h0000);
        vcf_host_i.launch(16'h0002, ok);
        rdc("diag run", 5'h03, 16'h0002);
        diag_test_done = 1'b1;
        @(posedge ref_clk) #1 diag_test_done = 1'b0;
        rdc("diag done", 5'h03, 16'h0000);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {rst_n, out_on, diag_result_valid, pwm_cycle_end, out_of_reg, ev} = '0;
        {current_sense_amp_crc_err, converter_trim_crc_err, diag_test_done, gnd_test_done} = '0;
        {failures, total_checks} = '0;
        logic_bist_status = VCF_BIST_IDLE;
        diag_result = VCF_DIAG_PASS;
        repeat (20) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_cfg();
        t_faults();
        t_oor();
        t_test();
        close_out();
    end
endmodule
